// file: design/gpio_mux_pkg.sv
// constants for the status-to-pin routing block: register map, field layout, function codes.
// assumes a 32-bit apb slave on pclk and sixteen general-purpose pins numbered from one.
package gpio_mux_pkg;

	localparam int          PIN_COUNT      = 16;
	localparam int          FUNC_W         = 10;
	localparam int          ADDR_W         = 12;
	localparam int          IRQ_W          = 8;

	// register byte addresses
	localparam logic [11:0] ADDR_FUNC_BASE = 12'h000;
	localparam logic [11:0] ADDR_FUNC_LAST = 12'h03C;
	localparam logic [11:0] ADDR_AUX_CTRL  = 12'h040;
	localparam logic [11:0] ADDR_IRQ_STAT  = 12'h044;
	localparam logic [11:0] ADDR_IRQ_MASK  = 12'h048;
	localparam logic [11:0] ADDR_RAW_STAT  = 12'h04C;
	localparam logic [11:0] ADDR_SWITCH    = 12'h2C8;

	// pin function codes
	localparam logic [9:0]  FN_NONE        = 10'h000;
	localparam logic [9:0]  FN_PWM0        = 10'h048;
	localparam logic [9:0]  FN_PWM1        = 10'h049;
	localparam logic [9:0]  FN_SPDIF       = 10'h04C;
	localparam logic [9:0]  FN_LOCK0       = 10'h088;
	localparam logic [9:0]  FN_LOCK1       = 10'h089;
	localparam logic [9:0]  FN_TIMER       = 10'h140;
	localparam logic [9:0]  FN_LOGFIFO     = 10'h150;
	localparam logic [9:0]  FN_ALARM0      = 10'h230;
	localparam logic [9:0]  FN_ALARM1      = 10'h231;
	localparam logic [9:0]  FN_ALARM2      = 10'h232;
	localparam logic [9:0]  FN_ALARM3      = 10'h233;
	localparam logic [9:0]  FN_PDM_CLK     = 10'h280;
	localparam logic [9:0]  FN_PDM_DAT     = 10'h281;

	// pins that may carry the auxiliary pdm signals
	localparam int          PDM_CLK_PIN_A  = 3;
	localparam int          PDM_CLK_PIN_B  = 10;
	localparam int          PDM_DAT_PIN_A  = 4;
	localparam int          PDM_DAT_PIN_B  = 9;

	// interrupt status / mask / raw layout
	localparam int          IRQ_LOCK0      = 0;
	localparam int          IRQ_LOCK1      = 1;
	localparam int          IRQ_TIMER      = 2;
	localparam int          IRQ_LOGFIFO    = 3;
	localparam int          IRQ_ALARM_LO   = 4;
	localparam int          IRQ_ALARM_HI   = 7;

	// switch control fields
	localparam int          SW1_LSB        = 0;
	localparam int          SW2_LSB        = 2;
	localparam logic [1:0]  SW_OPEN        = 2'h0;
	localparam logic [1:0]  SW_CLOSED      = 2'h1;
	localparam logic [1:0]  SW_IF_CLAMP    = 2'h2;
	localparam logic [1:0]  SW_IF_NO_CLAMP = 2'h3;
	localparam logic [3:0]  SWITCH_RESET   = 4'h0;

	localparam int          AUX_MASTER_BIT = 0;

endpackage

// file: design/gpio_status_output_mux.sv
// status-to-pin routing block with interrupt latches and analog switch control, apb slave.
// assumes source signals are pclk-synchronous; gpio_in comes from pins, and only its pin 10 bit is used and synchronised here.
//
// Behaviour
// - two pwm outputs can be routed to a pin by codes 0x048 and 0x049.
// - code 0x04C routes the s/pdif transmitter output to a pin.
// - codes 0x088 and 0x089 put the two rate-converter lock flags on a pin.
// - every rising or falling edge of a lock flag sets a sticky interrupt bit.
// - code 0x140 puts a pulse on the pin each time the timer reaches its final count.
// - each timer final count sets a sticky timer interrupt bit.
// - code 0x150 drives the pin high while the 16-stage event fifo is not empty.
// - the event fifo becoming non-empty sets a sticky interrupt bit.
// - codes 0x230 to 0x233 put the four alarm statuses on a pin.
// - each alarm trigger sets that alarm's sticky interrupt bit.
// - in pdm master mode the clock goes out on pin 3 or 10 and data on pin 4 or 9.
// - in pdm slave mode the clock comes in on pin 10 only and data goes out on pin 9 only.
// - switch one field 1:0 gives open, closed, closed while clamp set, closed while clamp clear; resets open.
// - switch two field 3:2 uses the same encoding and resets open.
// - a sticky interrupt bit stays set until software writes a one to it.
// - the interrupt output is the or of the unmasked sticky bits.
`timescale 1ns/1ps
module gpio_status_output_mux
	import gpio_mux_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [1:0]           pwm,
	input  wire logic                 spdif,
	input  wire logic [1:0]           rate_converter_lock,
	input  wire logic                 timer_tick,
	input  wire logic                 timer_final,
	input  wire logic                 log_not_empty,
	input  wire logic [3:0]           alarm_status,
	input  wire logic [3:0]           alarm_trigger,
	input  wire logic                 pdm_clk,
	input  wire logic                 pdm_dat,
	input  wire logic                 mic_detect_clamp,
	input  wire logic [PIN_COUNT-1:0] gpio_in,
	output logic      [PIN_COUNT-1:0] gpio_out,
	output logic      [PIN_COUNT-1:0] gpio_oe_n,
	output logic                      pdm_clk_in,
	output logic                      switch_one_pos_pin,
	output logic                      switch_two_pos_pin,
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////////
	// apb front end

	logic              pready_r;
	logic              pready_nxt;
	logic              pslverr_r;
	logic              pslverr_nxt;
	logic [31:0]       prdata_r;
	logic [31:0]       prdata_nxt;
	logic              wr_en;
	logic              setup;
	logic              func_hit;
	logic [3:0]        func_idx;

	logic [FUNC_W-1:0] func_r   [PIN_COUNT];
	logic [FUNC_W-1:0] func_nxt [PIN_COUNT];
	logic              aux_master_r;
	logic              aux_master_nxt;
	logic [3:0]        switch_r;
	logic [3:0]        switch_nxt;
	logic [IRQ_W-1:0]  irq_status_r;
	logic [IRQ_W-1:0]  irq_status_nxt;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [IRQ_W-1:0]  irq_mask_nxt;
	logic [IRQ_W-1:0]  raw_status;
	logic [IRQ_W-1:0]  set_vec;
	logic [IRQ_W-1:0]  clr_vec;

	assign setup    = psel && !penable;
	assign wr_en    = psel && penable && pready_r && pwrite;
	assign func_hit = (paddr >= ADDR_FUNC_BASE) && (paddr <= ADDR_FUNC_LAST) && (paddr[1:0] == 2'h0);
	assign func_idx = paddr[5:2];

	// read data is captured in the setup cycle so that pready and prdata leave flops
	always_comb begin
		pready_nxt  = setup;
		pslverr_nxt = 1'b0;
		prdata_nxt  = prdata_r;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			if (func_hit) begin
				prdata_nxt[FUNC_W-1:0] = func_r[func_idx];
			end else begin
				case (paddr)
					ADDR_AUX_CTRL: prdata_nxt[AUX_MASTER_BIT] = aux_master_r;
					ADDR_IRQ_STAT: prdata_nxt[IRQ_W-1:0] = irq_status_r;
					ADDR_IRQ_MASK: prdata_nxt[IRQ_W-1:0] = irq_mask_r;
					ADDR_RAW_STAT: prdata_nxt[IRQ_W-1:0] = raw_status;
					ADDR_SWITCH:   prdata_nxt[3:0] = switch_r;
					default:       pslverr_nxt = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			func_nxt[i] = func_r[i];
		end
		aux_master_nxt = aux_master_r;
		switch_nxt     = switch_r;
		irq_mask_nxt   = irq_mask_r;
		if (wr_en) begin
			if (func_hit) begin
				func_nxt[func_idx] = pwdata[FUNC_W-1:0];
			end
			case (paddr)
				ADDR_AUX_CTRL: aux_master_nxt = pwdata[AUX_MASTER_BIT];
				ADDR_IRQ_MASK: irq_mask_nxt = pwdata[IRQ_W-1:0];
				ADDR_SWITCH:   switch_nxt = pwdata[3:0];
				default:       aux_master_nxt = aux_master_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				func_r[i] <= FN_NONE;
			end
			aux_master_r <= 1'b0;
			switch_r     <= SWITCH_RESET;
			irq_mask_r   <= '0;
		end else begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				func_r[i] <= func_nxt[i];
			end
			aux_master_r <= aux_master_nxt;
			switch_r     <= switch_nxt;
			irq_mask_r   <= irq_mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event detection, sticky status, interrupt

	logic [1:0] lock_prev_r;
	logic       log_prev_r;
	logic       irq_r;
	logic       irq_nxt;

	assign raw_status = {alarm_status, log_not_empty, timer_final, rate_converter_lock};

	always_comb begin
		set_vec                           = '0;
		set_vec[IRQ_LOCK1:IRQ_LOCK0]      = rate_converter_lock ^ lock_prev_r;
		set_vec[IRQ_TIMER]                = timer_final;
		set_vec[IRQ_LOGFIFO]              = log_not_empty && !log_prev_r;
		set_vec[IRQ_ALARM_HI:IRQ_ALARM_LO] = alarm_trigger;
		clr_vec = (wr_en && (paddr == ADDR_IRQ_STAT)) ? pwdata[IRQ_W-1:0] : '0;
		// a new event in the clearing cycle survives the clear
		irq_status_nxt = (irq_status_r & ~clr_vec) | set_vec;
		irq_nxt        = |(irq_status_r & irq_mask_r);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_prev_r  <= 2'h0;
			log_prev_r   <= 1'b0;
			irq_status_r <= '0;
			irq_r        <= 1'b0;
		end else begin
			lock_prev_r  <= rate_converter_lock;
			log_prev_r   <= log_not_empty;
			irq_status_r <= irq_status_nxt;
			irq_r        <= irq_nxt;
		end
	end

	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////////
	// timer pulse, switches, pdm clock input

	logic timer_pin_r;
	logic timer_pin_nxt;
	logic sw1_r;
	logic sw1_nxt;
	logic sw2_r;
	logic sw2_nxt;
	logic pdm_sync1_r;
	logic pdm_sync2_r;
	logic pdm_clk_in_r;
	logic pdm_clk_in_nxt;

	function automatic logic switch_closed(input logic [1:0] mode, input logic clamp);
		logic c;
		case (mode)
			SW_CLOSED:      c = 1'b1;
			SW_IF_CLAMP:    c = clamp;
			SW_IF_NO_CLAMP: c = !clamp;
			default:        c = 1'b0;
		endcase
		return c;
	endfunction

	always_comb begin
		// held from the final-count tick until the timer's next tick
		timer_pin_nxt = timer_pin_r;
		if (timer_tick) begin
			timer_pin_nxt = timer_final;
		end
		sw1_nxt = switch_closed(switch_r[SW1_LSB+1:SW1_LSB], mic_detect_clamp);
		sw2_nxt = switch_closed(switch_r[SW2_LSB+1:SW2_LSB], mic_detect_clamp);
		// slave clock only accepted on pin 10 when it is set up for the pdm clock
		pdm_clk_in_nxt = !aux_master_r && (func_r[PDM_CLK_PIN_B-1] == FN_PDM_CLK) && pdm_sync2_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_pin_r  <= 1'b0;
			sw1_r        <= 1'b0;
			sw2_r        <= 1'b0;
			pdm_sync1_r  <= 1'b0;
			pdm_sync2_r  <= 1'b0;
			pdm_clk_in_r <= 1'b0;
		end else begin
			timer_pin_r  <= timer_pin_nxt;
			sw1_r        <= sw1_nxt;
			sw2_r        <= sw2_nxt;
			pdm_sync1_r  <= gpio_in[PDM_CLK_PIN_B-1];
			pdm_sync2_r  <= pdm_sync1_r;
			pdm_clk_in_r <= pdm_clk_in_nxt;
		end
	end

	assign switch_one_pos_pin = sw1_r;
	assign switch_two_pos_pin = sw2_r;
	assign pdm_clk_in         = pdm_clk_in_r;

	////////////////////////////////////////////////////////////////////////////
	// per-pin selectors

	for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
		pin_output_select #(
			.PIN_NUM       (g + 1)
		) u_sel (
			.pclk          (pclk),
			.presetn       (presetn),
			.func_code     (func_r[g]),
			.aux_master    (aux_master_r),
			.pwm           (pwm),
			.spdif         (spdif),
			.lock          (rate_converter_lock),
			.timer_pin     (timer_pin_r),
			.log_not_empty (log_not_empty),
			.alarm         (alarm_status),
			.pdm_clk       (pdm_clk),
			.pdm_dat       (pdm_dat),
			.pin_out       (gpio_out[g]),
			.pin_oe_n      (gpio_oe_n[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_lock_edge;
		@(posedge pclk) disable iff (!presetn)
		(rate_converter_lock[0] != $past(rate_converter_lock[0])) |=> irq_status_r[IRQ_LOCK0];
	endproperty
	a_lock_edge: assert property (p_lock_edge) else $error("lock edge not latched");

	property p_timer_irq;
		@(posedge pclk) disable iff (!presetn)
		timer_final |=> irq_status_r[IRQ_TIMER];
	endproperty
	a_timer_irq: assert property (p_timer_irq) else $error("timer event not latched");

	property p_log_irq;
		@(posedge pclk) disable iff (!presetn)
		$rose(log_not_empty) |=> irq_status_r[IRQ_LOGFIFO];
	endproperty
	a_log_irq: assert property (p_log_irq) else $error("fifo event not latched");

	property p_alarm_irq;
		@(posedge pclk) disable iff (!presetn)
		(|alarm_trigger) |=> ((irq_status_r[IRQ_ALARM_HI:IRQ_ALARM_LO] & $past(alarm_trigger)) == $past(alarm_trigger));
	endproperty
	a_alarm_irq: assert property (p_alarm_irq) else $error("alarm event not latched");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (($past(irq_status_r) & ~$past(clr_vec) & ~irq_status_r) == '0);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

	property p_irq_out;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (irq == $past(|(irq_status_r & irq_mask_r)));
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq not raised");

	property p_timer_hold;
		@(posedge pclk) disable iff (!presetn)
		(timer_pin_r && !timer_tick) |=> timer_pin_r;
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("timer pulse cut short");

	property p_timer_end;
		@(posedge pclk) disable iff (!presetn)
		(timer_pin_r && timer_tick && !timer_final) |=> !timer_pin_r;
	endproperty
	a_timer_end: assert property (p_timer_end) else $error("timer pulse too long");

	property p_sw1_clamp;
		@(posedge pclk) disable iff (!presetn)
		(switch_r[SW1_LSB+1:SW1_LSB] == SW_IF_CLAMP) |=> (switch_one_pos_pin == $past(mic_detect_clamp));
	endproperty
	a_sw1_clamp: assert property (p_sw1_clamp) else $error("switch one not tracking clamp");

	property p_sw2_noclamp;
		@(posedge pclk) disable iff (!presetn)
		(switch_r[SW2_LSB+1:SW2_LSB] == SW_IF_NO_CLAMP) |=> (switch_two_pos_pin == !$past(mic_detect_clamp));
	endproperty
	a_sw2_noclamp: assert property (p_sw2_noclamp) else $error("switch two not tracking clamp");

endmodule

// file: design/pin_output_select.sv
// one pin's output selector: picks a status source by function code and registers it.
// assumes all sources are on pclk; the enable is low while the pin is driven.
`timescale 1ns/1ps
module pin_output_select
	import gpio_mux_pkg::*;
#(
	parameter int PIN_NUM = 1
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [FUNC_W-1:0] func_code,
	input  wire logic              aux_master,
	input  wire logic [1:0]        pwm,
	input  wire logic              spdif,
	input  wire logic [1:0]        lock,
	input  wire logic              timer_pin,
	input  wire logic              log_not_empty,
	input  wire logic [3:0]        alarm,
	input  wire logic              pdm_clk,
	input  wire logic              pdm_dat,
	output logic                   pin_out,
	output logic                   pin_oe_n
);

	localparam logic CLK_OK_M = (PIN_NUM == PDM_CLK_PIN_A) || (PIN_NUM == PDM_CLK_PIN_B);
	localparam logic DAT_OK_M = (PIN_NUM == PDM_DAT_PIN_A) || (PIN_NUM == PDM_DAT_PIN_B);
	localparam logic DAT_OK_S = (PIN_NUM == PDM_DAT_PIN_B);

	logic out_r;
	logic out_nxt;
	logic oe_n_r;
	logic oe_n_nxt;

	always_comb begin
		out_nxt  = 1'b0;
		oe_n_nxt = 1'b0;
		case (func_code)
			FN_PWM0:    out_nxt = pwm[0];
			FN_PWM1:    out_nxt = pwm[1];
			FN_SPDIF:   out_nxt = spdif;
			FN_LOCK0:   out_nxt = lock[0];
			FN_LOCK1:   out_nxt = lock[1];
			FN_TIMER:   out_nxt = timer_pin;
			FN_LOGFIFO: out_nxt = log_not_empty;
			FN_ALARM0:  out_nxt = alarm[0];
			FN_ALARM1:  out_nxt = alarm[1];
			FN_ALARM2:  out_nxt = alarm[2];
			FN_ALARM3:  out_nxt = alarm[3];
			FN_PDM_CLK: begin
				// slave mode: clock comes in on a pin, so never drive it
				if (aux_master && CLK_OK_M) begin
					out_nxt = pdm_clk;
				end else begin
					oe_n_nxt = 1'b1;
				end
			end
			FN_PDM_DAT: begin
				if ((aux_master && DAT_OK_M) || (!aux_master && DAT_OK_S)) begin
					out_nxt = pdm_dat;
				end else begin
					oe_n_nxt = 1'b1;
				end
			end
			default:    oe_n_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r  <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			out_r  <= out_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign pin_out  = out_r;
	assign pin_oe_n = oe_n_r;

	property p_log_pin;
		@(posedge pclk) disable iff (!presetn)
		(func_code == FN_LOGFIFO) |=> (!pin_oe_n && (pin_out == $past(log_not_empty)));
	endproperty
	a_log_pin: assert property (p_log_pin) else $error("fifo status pin wrong");

	property p_lock_pin;
		@(posedge pclk) disable iff (!presetn)
		(func_code == FN_LOCK1) |=> (!pin_oe_n && (pin_out == $past(lock[1])));
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");

endmodule

// file: tb/pin_partner.sv
// far side of the pins: an external processor that may supply the slave pdm clock on gpio10.
// assumes the block's pin outputs; released pins show a toggling pattern, not a held value, except gpio10 while the external clock is enabled.
`timescale 1ns/1ps
module pin_partner
	import gpio_mux_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic [PIN_COUNT-1:0] gpio_out,
	input  wire logic [PIN_COUNT-1:0] gpio_oe_n,
	input  wire logic                 clk_en,
	input  wire logic                 clk_lvl,
	output logic      [PIN_COUNT-1:0] gpio_in
);
	logic tog_r;

	// free-running pattern; leaves x on its own without an initialiser
	always_ff @(posedge pclk) begin
		tog_r <= (tog_r !== 1'b1);
	end

	// a pin driven by the block wins; the external clock only goes on gpio10
	always_comb begin
		for (int g = 0; g < PIN_COUNT; g++) begin
			if (!gpio_oe_n[g])
				gpio_in[g] = gpio_out[g];
			else if (g == PDM_CLK_PIN_B - 1 && clk_en)
				gpio_in[g] = clk_lvl;
			else
				gpio_in[g] = tog_r;
		end
	end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the status-to-pin routing block.
// assumes the design package and the pin partner model; apb master on pclk.
`timescale 1ns/1ps
module tb_top
	import gpio_mux_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [1:0]        pwm, lock;
	logic              spdif, timer_tick, timer_final, log_ne, pdm_clk, pdm_dat, clamp;
	logic [3:0]        al_st, al_tr;
	logic [15:0]       gpio_in, gpio_out, gpio_oe_n;
	logic              pdm_clk_in, sw1, sw2, irq, ext_en, ext_lvl, er;
	int                err_total, tests_run;

	gpio_status_output_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm(pwm), .spdif(spdif), .rate_converter_lock(lock),
		.timer_tick(timer_tick), .timer_final(timer_final), .log_not_empty(log_ne),
		.alarm_status(al_st), .alarm_trigger(al_tr), .pdm_clk(pdm_clk), .pdm_dat(pdm_dat),
		.mic_detect_clamp(clamp), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.pdm_clk_in(pdm_clk_in), .switch_one_pos_pin(sw1), .switch_two_pos_pin(sw2), .irq(irq));

	pin_partner u_partner (.pclk(pclk), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.clk_en(ext_en), .clk_lvl(ext_lvl), .gpio_in(gpio_in));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// holds the request until pready is seen high at a rising edge
	task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(er, 32'h0000_0000);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task setfn(input int i, input logic [9:0] c);
		wr(ADDR_FUNC_BASE + 12'(4 * i), 32'(c));
	endtask

	task settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task src(input logic v);
		pwm <= v ? 2'h1 : 2'h2;
		spdif <= v;
		lock <= v ? 2'h2 : 2'h1;
		log_ne <= v;
		al_st <= v ? 4'h5 : 4'hA;
	endtask

	function automatic logic sw_exp(input int m, input int c);
		case (m)
			0: return 1'b0;
			1: return 1'b1;
			2: return c[0];
			default: return !c[0];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	task t_reset;
		chk(gpio_oe_n, 32'h0000_FFFF);
		chk({irq, sw1, sw2, pdm_clk_in}, 32'h0000_0000);
		rdc(ADDR_SWITCH, 32'h0000_0000);
		rdc(ADDR_IRQ_MASK, 32'h0000_0000);
		rdc(ADDR_FUNC_BASE, 32'h0000_0000);
	endtask

	// ten pins at once, then every source inverted so a stuck pin shows
	task t_mux;
		logic [9:0] codes [10];
		codes = '{FN_PWM0, FN_PWM1, FN_SPDIF, FN_LOCK0, FN_LOCK1, FN_LOGFIFO,
			FN_ALARM0, FN_ALARM1, FN_ALARM2, FN_ALARM3};
		@(posedge pclk);
		src(1'b1);
		for (int i = 0; i < 10; i++)
			setfn(i, codes[i]);
		setfn(10, 10'h3FF);
		settle(3);
		chk(gpio_out[9:0], 32'h0000_0175);
		chk(gpio_oe_n[10:0], 32'h0000_0400);
		@(posedge pclk);
		src(1'b0);
		settle(3);
		chk(gpio_out[9:0], 32'h0000_028A);
	endtask

	task t_pdm;
		wr(ADDR_AUX_CTRL, 32'h0000_0001);
		setfn(2, FN_PDM_CLK);
		setfn(9, FN_PDM_CLK);
		setfn(3, FN_PDM_DAT);
		setfn(8, FN_PDM_DAT);
		pdm_clk <= 1'b1;
		ext_en <= 1'b1;
		ext_lvl <= 1'b1;
		settle(4);
		chk({gpio_out[9], gpio_out[8], gpio_out[3], gpio_out[2]}, 32'h0000_0009);
		chk({gpio_oe_n[9], gpio_oe_n[8], gpio_oe_n[3], gpio_oe_n[2]}, 32'h0000_0000);
		chk(pdm_clk_in, 32'h0000_0000);
		pdm_clk <= 1'b0;
		pdm_dat <= 1'b1;
		settle(3);
		chk({gpio_out[9], gpio_out[8], gpio_out[3], gpio_out[2]}, 32'h0000_0006);
		wr(ADDR_AUX_CTRL, 32'h0000_0000);
		settle(4);
		chk({gpio_oe_n[9], gpio_oe_n[8], gpio_oe_n[3], gpio_oe_n[2]}, 32'h0000_000B);
		chk({gpio_out[8], pdm_clk_in}, 32'h0000_0003);
		ext_lvl <= 1'b0;
		settle(5);
		chk(pdm_clk_in, 32'h0000_0000);
		ext_en <= 1'b0;
	endtask

	task t_irq;
		wr(ADDR_IRQ_MASK, 32'h0000_00FF);
		wr(ADDR_IRQ_STAT, 32'h0000_00FF);
		rdc(ADDR_IRQ_STAT, 32'h0000_0000);
		@(posedge pclk);
		lock <= ~lock;
		timer_final <= 1'b1;
		log_ne <= 1'b1;
		al_tr <= 4'hF;
		@(posedge pclk);
		timer_final <= 1'b0;
		al_tr <= 4'h0;
		settle(3);
		rdc(ADDR_IRQ_STAT, 32'h0000_00FF);
		chk(irq, 32'h0000_0001);
		wr(ADDR_IRQ_STAT, 32'h0000_0000);
		rdc(ADDR_IRQ_STAT, 32'h0000_00FF);
		wr(ADDR_IRQ_STAT, 32'h0000_000F);
		rdc(ADDR_IRQ_STAT, 32'h0000_00F0);
		wr(ADDR_IRQ_MASK, 32'h0000_000F);
		settle(2);
		chk(irq, 32'h0000_0000);
		wr(ADDR_IRQ_STAT, 32'h0000_00F0);
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		@(posedge pclk);
		lock <= ~lock;
		settle(3);
		rdc(ADDR_IRQ_STAT, 32'h0000_0003);
		chk(irq, 32'h0000_0001);
		wr(ADDR_IRQ_STAT, 32'h0000_0003);
		rdc(ADDR_RAW_STAT, 32'h0000_00A9);
	endtask

	task t_timer;
		int hi;
		setfn(0, FN_TIMER);
		settle(3);
		hi = 0;
		@(posedge pclk);
		timer_final <= 1'b1;
		@(posedge pclk);
		timer_final <= 1'b0;
		repeat (6) begin
			@(negedge pclk);
			if (gpio_out[0] === 1'b1)
				hi++;
		end
		chk(hi, 32'h0000_0001);
		// slow tick: the pulse must span one whole tick period of four cycles
		hi = 0;
		for (int c = 0; c < 16; c++) begin
			@(negedge pclk);
			if (gpio_out[0] === 1'b1)
				hi++;
			@(posedge pclk);
			timer_tick  <= (c % 4 == 3);
			timer_final <= (c == 3);
		end
		chk(hi, 32'h0000_0004);
		rdc(ADDR_IRQ_STAT, 32'h0000_0004);
	endtask

	// every mode on both switches against both clamp levels
	task t_sw;
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 2; k++) begin
				@(posedge pclk);
				clamp <= k[0];
				wr(ADDR_SWITCH, 32'((3 - m) * 4 + m));
				settle(2);
				chk({sw1, sw2}, {sw_exp(m, k), sw_exp(3 - m, k)});
			end
		end
		rdc(ADDR_SWITCH, 32'h0000_0003);
	endtask

	task t_unmapped;
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk(er, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 12'h100, 32'hFFFF_FFFF);
		chk(er, 32'h0000_0001);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, spdif, timer_final, log_ne, pdm_clk, pdm_dat, clamp, ext_en, ext_lvl} = '0;
		{paddr, pwdata, pwm, lock, al_st, al_tr} = '0;
		timer_tick = 1'b1;
		presetn = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		t_reset;
		t_mux;
		t_pdm;
		t_irq;
		t_timer;
		t_sw;
		t_unmapped;
		report_and_stop;
	end

	initial begin
		#200us;
		err_total++;
		report_and_stop;
	end
endmodule
